// >>> core/cbb_bridge.sv
// Core bus bridge: write buffer, read buffer, prefetch and response FIFO
`timescale 1ns/1ps

// =========================================
// Response FIFO
module cbb_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_reg;
    logic [AW-1:0] rdPtr_reg;
    logic [CW-1:0] count_reg;
    logic doWr;
    logic doRd;

    assign inReady = count_reg != FULL;
    assign outValid = count_reg != '0;
    assign outData = mem[rdPtr_reg];
    assign doWr = inValid && inReady;
    assign doRd = outValid && outReady;

    always_ff @(posedge clk) begin
        if (doWr) begin
            mem[wrPtr_reg] <= inData;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (doWr) begin
                wrPtr_reg <= wrPtr_reg + 1'b1;
            end
            if (doRd) begin
                rdPtr_reg <= rdPtr_reg + 1'b1;
            end
            if (doWr && !doRd) begin
                count_reg <= count_reg + 1'b1;
            end else if (doRd && !doWr) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule

// What this block does
// - Core accesses are served in order; only fetches may pass queued writes.
// - Core addresses reach the system bus unchanged.
// - Bus side is decoupled; all data crossing is held in buffers.
// - Two write entries, each one address plus sixteen data bytes.
// - One sixteen-byte read buffer holds data until the response FIFO takes it.
// - Only core-enabled bytes move; no widening of narrow accesses.
// - No byte merging and no collapsing of repeated writes.
// - Two outstanding writes, four when merging pairs them.
// - Fetch goes before unstarted writes, never before a started one.
// - Fetch address is never checked against buffered write addresses.
// - With prefetch on, fetches grow by sixteen bytes kept as valid.
// - Short delivery of the extra bytes leaves prefetch buffer invalid.
// - Fetch matching the valid prefetch address is served without bus access.
// - Non-matching fetch goes to the bus even if bytes are buffered.
// - Prefetch and merging have separate independent enables.
// - Only a dword pair at offsets 0 and 4, or 8 and 12, of one quadword merges.
// - Merge happens as the second write enters the buffer.
// - Writes never wait for partners; merge only before first starts.
// - A fetch between two mergeable writes does not block merging.
// - Atomic add and modify run as locked read then locked write.
// - Core bus is 32 bits wide; byte reads still pass for boot record.
module cbb_bridge (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Controls
    input wire logic prefetchEnable,
    input wire logic mergeEnable,
    // Core requests
    input wire logic coreReqValid,
    input wire cbb_pkg::cbb_core_req_t coreReq,
    output logic coreReqReady,
    // Core responses
    output logic coreRspValid,
    output logic [31:0] coreRspData,
    input wire logic coreRspReady,
    // Shared system bus
    output logic ibReq,
    output cbb_pkg::cbb_ib_cmd_t ibCmd,
    input wire logic ibAck,
    input wire cbb_pkg::cbb_ib_rsp_t ibRsp
);
    import cbb_pkg::*;

    // =========================================
    // Declarations
    cbb_core_req_t pend_reg;
    logic pendValid_reg;
    logic ready_reg;
    cbb_core_req_t opReq_reg;
    logic opPf_reg;
    cbb_op_t opTag_reg;
    cbb_state_t state_reg;
    logic ibReq_reg;
    cbb_ib_cmd_t ibCmd_reg;
    cbb_ib_rsp_t rspCap_reg;
    logic ackMeta_reg;
    logic ackS_reg;
    logic [31:0] wbAddr [WB_DEPTH];
    logic [127:0] wbData [WB_DEPTH];
    logic [15:0] wbBe [WB_DEPTH];
    logic [WB_DEPTH-1:0] wbStarted_reg;
    logic [WB_DEPTH-1:0] wbSingle_reg;
    logic wbHead_reg;
    logic [1:0] wbCount_reg;
    logic pfValid_reg;
    logic [31:0] pfAddr_reg;
    logic [127:0] pfData_reg;
    logic [127:0] rbData_reg;
    logic [2:0] rbCount_reg;
    logic rspValid_reg;
    logic [31:0] rspData_reg;
    logic tail;
    logic isFetch;
    logic isWrite;
    logic pfHit;
    logic headBlocks;
    logic mergeOk;
    logic wrPush;
    logic goHit;
    logic goFetch;
    logic goRead;
    logic goWrite;
    logic done;
    logic wbPop;
    logic fifoInReady;
    logic fifoOutValid;
    logic [31:0] fifoOutData;
    logic fifoOutReady;
    logic [5:0] baseLen;
    logic [5:0] entryOfs;
    logic [31:0] atomicOld;
    logic [31:0] atomicNew;

    assign coreReqReady = ready_reg;
    assign ibReq = ibReq_reg;
    assign ibCmd = ibCmd_reg;
    assign coreRspValid = rspValid_reg;
    assign coreRspData = rspData_reg;

    // =========================================
    // Decisions
    assign tail = wbHead_reg ^ (wbCount_reg == 2'h2);
    assign isFetch = pend_reg.kind == K_FETCH;
    assign isWrite = pend_reg.kind == K_WRITE;
    assign pfHit = prefetchEnable && pfValid_reg
        && (pfAddr_reg == pend_reg.addr);
    assign headBlocks = (wbCount_reg != 2'h0) && wbStarted_reg[wbHead_reg];
    assign mergeOk = mergeEnable && pendValid_reg && isWrite
        && (pend_reg.be == DWORD_BE)
        && (pend_reg.addr[2:0] == MERGE_SECOND_OFS)
        && (wbCount_reg != 2'h0) && !wbStarted_reg[tail]
        && wbSingle_reg[tail]
        && (wbAddr[tail][31:3] == pend_reg.addr[31:3])
        && (wbAddr[tail][2:0] == MERGE_FIRST_OFS);
    assign wrPush = pendValid_reg && isWrite && !mergeOk
        && (wbCount_reg != 2'h2);
    assign goHit = (state_reg == ST_IDLE) && pendValid_reg && isFetch && pfHit;
    assign goFetch = (state_reg == ST_IDLE) && pendValid_reg && isFetch
        && !pfHit && !headBlocks;
    assign goRead = (state_reg == ST_IDLE) && pendValid_reg && !isFetch
        && !isWrite && (wbCount_reg == 2'h0);
    assign goWrite = (state_reg == ST_IDLE) && (wbCount_reg != 2'h0)
        && !goHit && !goFetch && !goRead;
    assign done = (state_reg == ST_RELEASE) && !ackS_reg;
    assign wbPop = done && (opTag_reg == OP_WRITE) && !rspCap_reg.retry;
    assign baseLen = opReq_reg.fetchLong ? FETCH_LONG_BYTES
        : FETCH_SHORT_BYTES;
    assign entryOfs = {2'h0, pend_reg.addr[3:2], 2'h0};
    assign atomicOld = rspCap_reg.rdata[31:0];
    assign atomicNew = (opReq_reg.kind == K_ATADD)
        ? atomicOld + opReq_reg.data
        : (atomicOld & ~opReq_reg.aux) | (opReq_reg.data & opReq_reg.aux);

    // =========================================
    // Core request holding register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pendValid_reg <= 1'b0;
            ready_reg <= 1'b1;
            pend_reg <= '0;
        end else if (coreReqValid && ready_reg) begin
            pendValid_reg <= 1'b1;
            ready_reg <= 1'b0;
            pend_reg <= coreReq;
        end else if (mergeOk || wrPush || goHit || goFetch || goRead) begin
            pendValid_reg <= 1'b0;
            ready_reg <= 1'b1;
        end
    end

    // =========================================
    // Acknowledge synchroniser
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ackMeta_reg <= 1'b0;
            ackS_reg <= 1'b0;
        end else begin
            ackMeta_reg <= ibAck;
            ackS_reg <= ackMeta_reg;
        end
    end

    // =========================================
    // Write buffer storage
    always_ff @(posedge clk) begin
        if (mergeOk) begin
            wbData[tail] <= wbData[tail]
                | (128'(pend_reg.data) << {entryOfs, 3'h0});
            wbBe[tail] <= wbBe[tail] | (16'(pend_reg.be) << entryOfs);
        end else if (wrPush) begin
            wbAddr[tail ^ (wbCount_reg != 2'h0)] <= pend_reg.addr;
            wbData[tail ^ (wbCount_reg != 2'h0)] <=
                128'(pend_reg.data) << {entryOfs, 3'h0};
            wbBe[tail ^ (wbCount_reg != 2'h0)] <=
                16'(pend_reg.be) << entryOfs;
        end
    end

    // Write buffer control
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wbHead_reg <= 1'b0;
            wbCount_reg <= 2'h0;
            wbStarted_reg <= '0;
            wbSingle_reg <= '0;
        end else begin
            if (mergeOk) begin
                wbSingle_reg[tail] <= 1'b0;
            end else if (wrPush) begin
                wbSingle_reg[tail ^ (wbCount_reg != 2'h0)] <=
                    pend_reg.be == DWORD_BE;
                wbStarted_reg[tail ^ (wbCount_reg != 2'h0)] <= 1'b0;
            end
            if (goWrite) begin
                wbStarted_reg[wbHead_reg] <= 1'b1;
            end
            if (wbPop) begin
                wbHead_reg <= ~wbHead_reg;
                wbStarted_reg[wbHead_reg] <= 1'b0;
            end
            if (wrPush && !wbPop) begin
                wbCount_reg <= wbCount_reg + 2'h1;
            end else if (wbPop && !wrPush) begin
                wbCount_reg <= wbCount_reg - 2'h1;
            end
        end
    end

    // =========================================
    // Bus handshake sequencer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            opTag_reg <= OP_WRITE;
            opReq_reg <= '0;
            opPf_reg <= 1'b0;
            ibReq_reg <= 1'b0;
            ibCmd_reg <= '0;
            rspCap_reg <= '0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (goFetch || goRead) begin
                        opReq_reg <= pend_reg;
                        opPf_reg <= prefetchEnable;
                        opTag_reg <= goFetch ? OP_FETCH
                            : (pend_reg.kind == K_READ ? OP_READ : OP_ATRD);
                        ibReq_reg <= 1'b1;
                        ibCmd_reg.addr <= pend_reg.addr;
                        ibCmd_reg.wdata <= '0;
                        ibCmd_reg.be <= 16'(pend_reg.be);
                        ibCmd_reg.lenBytes <= !goFetch ? 6'h04
                            : (pend_reg.fetchLong ? FETCH_LONG_BYTES
                            : FETCH_SHORT_BYTES)
                            + (prefetchEnable ? PREFETCH_BYTES : 6'h00);
                        ibCmd_reg.isWrite <= 1'b0;
                        ibCmd_reg.lock <= !goFetch
                            && (pend_reg.kind != K_READ);
                        state_reg <= ST_REQ;
                    end else if (goWrite) begin
                        opTag_reg <= OP_WRITE;
                        ibReq_reg <= 1'b1;
                        ibCmd_reg.addr <= wbAddr[wbHead_reg];
                        ibCmd_reg.wdata <= wbData[wbHead_reg];
                        ibCmd_reg.be <= wbBe[wbHead_reg];
                        ibCmd_reg.lenBytes <= QWORD_ENTRY_BYTES;
                        ibCmd_reg.isWrite <= 1'b1;
                        ibCmd_reg.lock <= 1'b0;
                        state_reg <= ST_REQ;
                    end else if (goHit) begin
                        state_reg <= ST_RESP;
                    end
                end
                ST_REQ: begin
                    if (ackS_reg) begin
                        rspCap_reg <= ibRsp;
                        ibReq_reg <= 1'b0;
                        state_reg <= ST_RELEASE;
                    end
                end
                ST_RELEASE: begin
                    if (!ackS_reg) begin
                        if (rspCap_reg.retry && opTag_reg != OP_WRITE) begin
                            ibReq_reg <= 1'b1;
                            state_reg <= ST_REQ;
                        end else if (opTag_reg == OP_WRITE) begin
                            state_reg <= ST_IDLE;
                        end else if (opTag_reg == OP_ATRD) begin
                            opTag_reg <= OP_ATWR;
                            ibReq_reg <= 1'b1;
                            ibCmd_reg.wdata <= 128'(atomicNew)
                                << {opReq_reg.addr[3:2], 5'h00};
                            ibCmd_reg.be <= 16'(DWORD_BE)
                                << {opReq_reg.addr[3:2], 2'h0};
                            ibCmd_reg.isWrite <= 1'b1;
                            state_reg <= ST_REQ;
                        end else begin
                            ibCmd_reg.lock <= 1'b0;
                            state_reg <= ST_RESP;
                        end
                    end
                end
                ST_RESP: begin
                    if (fifoInReady && rbCount_reg == 3'h1) begin
                        state_reg <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // =========================================
    // Read buffer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rbData_reg <= '0;
            rbCount_reg <= 3'h0;
        end else if (goHit) begin
            rbData_reg <= pfData_reg;
            rbCount_reg <= pend_reg.fetchLong ? DWORDS_LONG : DWORDS_SHORT;
        end else if (done && opTag_reg == OP_FETCH && !rspCap_reg.retry) begin
            rbData_reg <= rspCap_reg.rdata[127:0];
            rbCount_reg <= opReq_reg.fetchLong ? DWORDS_LONG : DWORDS_SHORT;
        end else if (done && opTag_reg == OP_READ && !rspCap_reg.retry) begin
            rbData_reg <= rspCap_reg.rdata[127:0];
            rbCount_reg <= DWORDS_SINGLE;
        end else if (done && opTag_reg == OP_ATRD && !rspCap_reg.retry) begin
            rbData_reg <= 128'(atomicOld);
            rbCount_reg <= DWORDS_SINGLE;
        end else if (state_reg == ST_RESP && fifoInReady) begin
            rbData_reg <= rbData_reg >> 32;
            rbCount_reg <= rbCount_reg - 3'h1;
        end
    end

    // =========================================
    // Prefetch buffer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pfValid_reg <= 1'b0;
            pfAddr_reg <= '0;
            pfData_reg <= '0;
        end else if (done && opTag_reg == OP_FETCH && !rspCap_reg.retry
            && opPf_reg) begin
            if (rspCap_reg.bytesDone < ibCmd_reg.lenBytes) begin
                pfValid_reg <= 1'b0;
            end else begin
                pfValid_reg <= 1'b1;
                pfAddr_reg <= opReq_reg.addr + 32'(baseLen);
                pfData_reg <= opReq_reg.fetchLong ? rspCap_reg.rdata[255:128]
                    : rspCap_reg.rdata[191:64];
            end
        end
    end

    // =========================================
    // Response path
    cbb_fifo #(
        .WIDTH(RSP_FIFO_WIDTH),
        .DEPTH(RSP_FIFO_DEPTH)
    ) rspFifo (
        .clk(clk),
        .rst(rst),
        .inValid(state_reg == ST_RESP),
        .inReady(fifoInReady),
        .inData(rbData_reg[31:0]),
        .outValid(fifoOutValid),
        .outReady(fifoOutReady),
        .outData(fifoOutData)
    );

    assign fifoOutReady = !rspValid_reg || coreRspReady;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rspValid_reg <= 1'b0;
            rspData_reg <= '0;
        end else if (fifoOutReady) begin
            rspValid_reg <= fifoOutValid;
            rspData_reg <= fifoOutData;
        end
    end

    // =========================================
    // Checks
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    a_read_order: assert property (
        $rose(ibReq_reg) && opTag_reg == OP_READ
        && $past(state_reg) == ST_IDLE |-> wbCount_reg == 2'h0)
        else $error("read issued with writes queued");
    a_addr_kept: assert property (
        $rose(ibReq_reg) && opTag_reg != OP_WRITE
        |-> ibCmd_reg.addr == opReq_reg.addr)
        else $error("bus address differs from core address");
    a_ack_sync: assert property (
        $rose(ackS_reg) |-> $past(ibAck, 2))
        else $error("acknowledge used before synchronising");
    a_wb_depth: assert property (
        wbCount_reg <= 2'h2)
        else $error("write buffer overfilled");
    a_no_collapse: assert property (
        wrPush && !wbPop |=> wbCount_reg == $past(wbCount_reg) + 2'h1)
        else $error("separate write not given its own entry");
    a_fetch_first: assert property (
        state_reg == ST_IDLE && pendValid_reg && isFetch && !pfHit
        && wbCount_reg != 2'h0 && !headBlocks
        |=> opTag_reg == OP_FETCH && ibReq_reg)
        else $error("fetch did not pass unstarted writes");
    a_fetch_len: assert property (
        $rose(ibReq_reg) && opTag_reg == OP_FETCH
        |-> ibCmd_reg.lenBytes == baseLen
        + (opPf_reg ? PREFETCH_BYTES : 6'h00))
        else $error("fetch length wrong");
    a_pf_abort: assert property (
        done && opTag_reg == OP_FETCH && !rspCap_reg.retry && opPf_reg
        && rspCap_reg.bytesDone < ibCmd_reg.lenBytes |=> !pfValid_reg)
        else $error("short prefetch left buffer valid");
    a_hit_no_bus: assert property (
        goHit |=> state_reg == ST_RESP && !ibReq_reg [*2])
        else $error("prefetch hit started a bus access");
    a_merge_pair: assert property (
        mergeOk |-> pend_reg.addr[2:0] == MERGE_SECOND_OFS
        && wbAddr[tail][31:3] == pend_reg.addr[31:3])
        else $error("merge of wrong address pair");
    a_atomic_lock: assert property (
        ibReq_reg && (opTag_reg == OP_ATRD || opTag_reg == OP_ATWR)
        |-> ibCmd_reg.lock)
        else $error("atomic access not locked");
endmodule

// >>> core/cbb_pkg.sv
// Shared constants and types for the core bus bridge
package cbb_pkg;
    // =========================================
    // Sizes
    localparam int WB_DEPTH = 2;
    localparam int RSP_FIFO_DEPTH = 16;
    localparam int RSP_FIFO_WIDTH = 32;
    localparam logic [5:0] FETCH_SHORT_BYTES = 6'h08;
    localparam logic [5:0] FETCH_LONG_BYTES = 6'h10;
    localparam logic [5:0] PREFETCH_BYTES = 6'h10;
    localparam logic [5:0] QWORD_ENTRY_BYTES = 6'h10;
    localparam logic [2:0] MERGE_FIRST_OFS = 3'h0;
    localparam logic [2:0] MERGE_SECOND_OFS = 3'h4;
    localparam logic [3:0] DWORD_BE = 4'hF;
    localparam logic [2:0] DWORDS_SHORT = 3'h2;
    localparam logic [2:0] DWORDS_LONG = 3'h4;
    localparam logic [2:0] DWORDS_SINGLE = 3'h1;

    // =========================================
    // Request kinds from the core
    typedef enum logic [2:0] {
        K_READ = 3'h0,
        K_WRITE = 3'h1,
        K_FETCH = 3'h2,
        K_ATADD = 3'h3,
        K_ATMOD = 3'h4
    } cbb_kind_t;

    // Operation in flight on the shared system bus
    typedef enum logic [2:0] {
        OP_WRITE = 3'h0,
        OP_READ = 3'h1,
        OP_FETCH = 3'h2,
        OP_ATRD = 3'h3,
        OP_ATWR = 3'h4
    } cbb_op_t;

    // Bridge sequencer states
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_REQ = 4'b0010,
        ST_RELEASE = 4'b0100,
        ST_RESP = 4'b1000
    } cbb_state_t;

    // =========================================
    // Carriers
    typedef struct packed {
        cbb_kind_t kind;
        logic [31:0] addr;
        logic [31:0] data;
        logic [31:0] aux;
        logic [3:0] be;
        logic fetchLong;
    } cbb_core_req_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [127:0] wdata;
        logic [15:0] be;
        logic [5:0] lenBytes;
        logic isWrite;
        logic lock;
    } cbb_ib_cmd_t;

    typedef struct packed {
        logic [255:0] rdata;
        logic retry;
        logic [5:0] bytesDone;
    } cbb_ib_rsp_t;
endpackage

// >>> tb/cbb_ib_model.sv
// Shared system bus model: byte memory behind a 4-phase handshake
`timescale 1ns/1ps
module cbb_ib_model (
    // Bus side
    input wire logic clk,
    input wire logic ibReq,
    input wire cbb_pkg::cbb_ib_cmd_t ibCmd,
    output cbb_pkg::cbb_ib_rsp_t ibRsp,
    output logic ibAck,
    // Scenario controls
    input wire logic [5:0] delay,
    input wire logic retryNext,
    input wire logic cutNext
);
    import cbb_pkg::*;
    logic [7:0] mem [logic [31:0]];
    logic [31:0] x;
    logic didRetry = 1'b0;
    cbb_ib_cmd_t cmdLog [$];
    int n;
    initial begin
        ibAck = 1'b0;
        ibRsp = '0;
        forever begin
            @(posedge clk);
            if (ibReq) begin
                repeat (delay) @(posedge clk);
                n = cutNext ? 8 : int'(ibCmd.lenBytes);
                #1 ibRsp.retry = retryNext && !didRetry;
                didRetry = ibRsp.retry;
                ibRsp.bytesDone = 6'(n);
                for (int i = 0; i < 32; i++) begin
                    x = ibCmd.addr + i;
                    ibRsp.rdata[8*i+:8] = mem.exists(x) ? mem[x] : 8'(x) ^ 8'hA5;
                    if (i >= n)
                        ibRsp.rdata[8*i+:8] = ~ibRsp.rdata[8*i+:8];
                    x = {ibCmd.addr[31:4], 4'h0} + i;
                    if (ibCmd.isWrite && !ibRsp.retry && i < 16 && ibCmd.be[i])
                        mem[x] = ibCmd.wdata[8*i+:8];
                end
                if (!ibRsp.retry)
                    cmdLog.push_back(ibCmd);
                ibAck = 1'b1;
                while (ibReq) @(posedge clk);
                // Released answer no longer shows old data
                #1 ibAck = 1'b0;
                ibRsp = ~ibRsp;
            end
        end
    end
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the core bus bridge
`timescale 1ns/1ps
module tb_top;
    import cbb_pkg::*;
    logic clk, rst, prefetchEnable, mergeEnable, coreReqValid, coreReqReady;
    logic coreRspValid, ibReq, ibAck, retryNext, cutNext;
    logic coreRspReady = 1'b0;
    logic [31:0] coreRspData, seed, a, r, old, rspQ [$];
    logic [31:0] fa [5] = '{32'h5000, 32'h5010, 32'h5018, 32'h6000, 32'h6008};
    logic [7:0] shadow [logic [31:0]];
    logic [5:0] delay;
    logic [3:0] be;
    cbb_core_req_t coreReq;
    cbb_ib_cmd_t ibCmd;
    cbb_ib_rsp_t ibRsp;
    int error_cnt = 0, n_checks = 0, n, i, t;
    cbb_bridge cbb_bridge_i (.clk(clk), .rst(rst),
        .prefetchEnable(prefetchEnable), .mergeEnable(mergeEnable),
        .coreReqValid(coreReqValid), .coreReq(coreReq),
        .coreReqReady(coreReqReady), .coreRspValid(coreRspValid),
        .coreRspData(coreRspData), .coreRspReady(coreRspReady),
        .ibReq(ibReq), .ibCmd(ibCmd), .ibAck(ibAck), .ibRsp(ibRsp));
    cbb_ib_model cbb_ib_model_i (.clk(clk), .ibReq(ibReq), .ibCmd(ibCmd),
        .ibRsp(ibRsp), .ibAck(ibAck), .delay(delay),
        .retryNext(retryNext), .cutNext(cutNext));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    function automatic logic [31:0] nextRand();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [31:0] expDw(logic [31:0] x);
        for (int k = 0; k < 4; k++)
            expDw[8*k+:8] = shadow.exists(x+k) ? shadow[x+k] : 8'(x+k) ^ 8'hA5;
    endfunction
    task automatic check(logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic fail();
        error_cnt++;
        end_sim();
    endtask
    task automatic putDw(logic [31:0] x, logic [31:0] d, logic [3:0] m);
        for (int k = 0; k < 4; k++)
            if (m[k]) shadow[x+k] = d[8*k+:8];
    endtask
    task automatic send(cbb_kind_t k, logic [31:0] x, logic [31:0] d,
            logic [3:0] m, logic lng);
        int w = 0;
        coreReq = '{k, x, d, 32'h0F0F0F0F, m, lng};
        coreReqValid = 1'b1;
        do @(posedge clk); while (!coreReqReady && ++w < 500);
        #1 coreReqValid = 1'b0;
        if (w == 500) fail();
        if (k == K_WRITE) putDw(x, d, m);
        @(posedge clk);
        #1;
    endtask
    task automatic getRsp(logic [31:0] exp);
        int w = 0;
        while (rspQ.size() == 0 && w++ < 2000) @(posedge clk);
        #1;
        if (rspQ.size() == 0) fail();
        check(rspQ.pop_front(), exp);
    endtask
    task automatic waitIdle();
        int w = 0, q = 0;
        while (q < 20 && w++ < 3000) begin
            @(posedge clk);
            q = (ibReq || ibAck) ? 0 : q + 1;
        end
        #1;
        if (q < 20) fail();
    endtask
    // Collect answers while the core stalls at random
    always @(posedge clk) begin
        if (coreRspValid && coreRspReady) rspQ.push_back(coreRspData);
        coreRspReady <= #1 |(nextRand() & 32'h3);
    end
    initial begin
        seed = 32'h000185F5;
        rst = 1'b1;
        {prefetchEnable, mergeEnable, coreReqValid, retryNext, cutNext} = '0;
        coreReq = '0;
        delay = 6'h02;
        repeat (6) @(posedge clk);
        #1 rst = 1'b0;
        for (n = 0; n < 24; n++) begin
            r = nextRand();
            a = {24'h000010, r[7:2], 2'h0};
            be = n % 3 ? 4'hF : 4'h1 << r[9:8];
            retryNext = r[10];
            send(K_WRITE, a, r, be, 1'b0);
            waitIdle();
            check(32'(cbb_ib_model_i.cmdLog[$].be), 32'(be) << 4 * a[3:2]);
            check(cbb_ib_model_i.cmdLog[$].addr >> 4, a >> 4);
            send(K_READ, a, 32'h0, 4'hF, 1'b0);
            getRsp(expDw(a));
        end
        retryNext = 1'b0;
        delay = 6'h28;
        for (n = 0; n < 3; n++) begin
            mergeEnable = n != 1;
            a = n == 2 ? 32'h00003004 : 32'h00003000;
            t = cbb_ib_model_i.cmdLog.size();
            send(K_WRITE, 32'h00002000, nextRand(), 4'hF, 1'b0);
            send(K_WRITE, a, nextRand(), 4'hF, 1'b0);
            send(K_WRITE, a + 4, nextRand(), 4'hF, 1'b0);
            waitIdle();
            check(cbb_ib_model_i.cmdLog.size() - t, n ? 3 : 2);
            check(32'(cbb_ib_model_i.cmdLog[$].be),
                n ? 32'(16'hF << (a[3:0] + 4)) : 32'hFF);
            send(K_READ, a + 4, 32'h0, 4'hF, 1'b0);
            getRsp(expDw(a + 4));
        end
        mergeEnable = 1'b0;
        old = expDw(32'h00004100);
        t = cbb_ib_model_i.cmdLog.size();
        send(K_WRITE, 32'h00004000, nextRand(), 4'hF, 1'b0);
        send(K_WRITE, 32'h00004100, nextRand(), 4'hF, 1'b0);
        send(K_FETCH, 32'h00004100, 32'h0, 4'hF, 1'b0);
        getRsp(old);
        getRsp(expDw(32'h00004104));
        waitIdle();
        check(32'(cbb_ib_model_i.cmdLog[t+1].isWrite), 32'h0);
        check(32'(cbb_ib_model_i.cmdLog[t+1].lenBytes), 32'h8);
        delay = 6'h02;
        prefetchEnable = 1'b1;
        t = cbb_ib_model_i.cmdLog.size();
        for (n = 0; n < 5; n++) begin
            a = fa[n];
            cutNext = n == 3;
            send(K_FETCH, a, 32'h0, 4'hF, n == 0);
            for (i = 0; i < (n ? 2 : 4); i++)
                getRsp(expDw(a + 4 * i));
        end
        cutNext = 1'b0;
        waitIdle();
        check(cbb_ib_model_i.cmdLog.size() - t, 4);
        check(32'(cbb_ib_model_i.cmdLog[t].lenBytes), 32'h20);
        check(32'(cbb_ib_model_i.cmdLog[t+1].lenBytes), 32'h18);
        for (n = 0; n < 2; n++) begin
            a = 32'h00007000 + 8 * n;
            old = expDw(a);
            r = nextRand();
            send(n ? K_ATMOD : K_ATADD, a, r, 4'hF, 1'b0);
            getRsp(old);
            putDw(a, n ? (old & ~32'h0F0F0F0F) | (r & 32'h0F0F0F0F)
                : old + r, 4'hF);
            waitIdle();
            check(32'(cbb_ib_model_i.cmdLog[$].lock), 32'h1);
            send(K_READ, a, 32'h0, 4'hF, 1'b0);
            getRsp(expDw(a));
        end
        end_sim();
    end
endmodule
